// ---- hw/sadc_control.sv ----
// Converter control block: register slave, conversion timing and interrupt.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps

module sadc_control (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [11:0] coreResult,
    output logic             converterPower,
    output logic [3:0]       channelSelect,
    output logic             channelConnect,
    output logic             resolution12,
    output logic             convClockTick,
    output logic             convBusy,
    output logic             irq,
    output logic [7:0]       irqVector
);

    // ==========================================================================
    // Decoding shared by the read and the write path.
    // ==========================================================================
    function automatic sadc_pkg::sadc_reg_t decodeReg(input logic [11:0] addr);
        sadc_pkg::sadc_reg_t r;
        r = sadc_pkg::SADC_REG_NONE;
        if (addr[1:0] == 2'h0) begin
            if (addr[11:2] == {2'h0, sadc_pkg::IDX_MODE}) begin
                r = sadc_pkg::SADC_REG_MODE;
            end else if (addr[11:2] == {2'h0, sadc_pkg::IDX_RES_HIGH}) begin
                r = sadc_pkg::SADC_REG_HIGH;
            end else if (addr[11:2] == {2'h0, sadc_pkg::IDX_RES_LOW}) begin
                r = sadc_pkg::SADC_REG_LOW;
            end else if (addr[11:2] == {2'h0, sadc_pkg::IDX_IRQ_STATUS}) begin
                r = sadc_pkg::SADC_REG_STATUS;
            end else if (addr[11:2] == {2'h0, sadc_pkg::IDX_IRQ_MASK}) begin
                r = sadc_pkg::SADC_REG_MASK;
            end
        end
        return r;
    endfunction : decodeReg

    // Converter clock code to divide ratio minus one.
    function automatic logic [4:0] divLastOf(input logic [1:0] code);
        logic [4:0] v;
        v = sadc_pkg::DIV_LAST_16;
        unique case (code)
            sadc_pkg::DIV_CODE_16: v = sadc_pkg::DIV_LAST_16;
            sadc_pkg::DIV_CODE_8:  v = sadc_pkg::DIV_LAST_8;
            sadc_pkg::DIV_CODE_1:  v = sadc_pkg::DIV_LAST_1;
            sadc_pkg::DIV_CODE_2:  v = sadc_pkg::DIV_LAST_2;
        endcase
        return v;
    endfunction : divLastOf

    // ==========================================================================
    // State of the whole block.
    // ==========================================================================
    // Every flop but the check counter busyCycles sits in one packed struct, so one process computes all next
    // values and one synchronous reset clears them together.
    // Results are cleared too, yet software must treat them as meaningless
    // until the first run has ended.
    sadc_pkg::sadc_state_t st;
    sadc_pkg::sadc_state_t next_st;

    logic                  awFire;
    logic                  wFire;
    logic                  wrEn;
    sadc_pkg::sadc_reg_t   wrReg;
    logic [7:0]            wrData;
    logic                  wrStrb0;
    logic                  wrLow;
    logic                  irqClear;
    logic                  tick;
    logic                  done;
    sadc_pkg::sadc_reg_t   rdReg;
    logic [7:0]            rdByte;

    // ==========================================================================
    // Bus handshakes; address and data are taken in either order.
    // ==========================================================================
    assign s_axi_awready = !st.awHeld && !st.bvalid;
    assign s_axi_wready  = !st.wHeld && !st.bvalid;
    assign s_axi_arready = !st.rvalid;
    assign awFire        = s_axi_awvalid && s_axi_awready;
    assign wFire         = s_axi_wvalid && s_axi_wready;
    assign wrEn          = (st.awHeld || awFire) && (st.wHeld || wFire) && !st.bvalid;
    assign wrReg         = decodeReg(st.awHeld ? st.awAddr : s_axi_awaddr);
    assign wrData        = st.wHeld ? st.wData : s_axi_wdata[7:0];
    assign wrStrb0       = st.wHeld ? st.wStrb0 : s_axi_wstrb[0];
    assign wrLow         = wrEn && wrStrb0;
    assign irqClear      = wrLow && (wrReg == sadc_pkg::SADC_REG_STATUS) && wrData[sadc_pkg::IRQ_DONE_BIT];
    assign rdReg         = decodeReg(s_axi_araddr);

    // Conversion timing: one tick per divided converter clock.
    assign tick = (st.fsm == sadc_pkg::SADC_CONV) && (st.divCnt == st.divLast);
    assign done = tick && (st.tickCnt == st.tickLast);

    // Read data of the addressed register; unused bits read as zero.
    always_comb begin
        rdByte = 8'h00;
        unique case (rdReg)
            sadc_pkg::SADC_REG_MODE:   rdByte = {st.enable, st.start, st.eoc, st.globalEn, st.inputSel};
            sadc_pkg::SADC_REG_HIGH:   rdByte = st.resHigh;
            sadc_pkg::SADC_REG_LOW:    rdByte = {1'b0, st.clkDiv[1], st.res12, st.clkDiv[0], st.resLow};
            sadc_pkg::SADC_REG_STATUS: rdByte = {7'h00, st.irqFlag};
            sadc_pkg::SADC_REG_MASK:   rdByte = {7'h00, st.irqEnable};
            sadc_pkg::SADC_REG_NONE:   rdByte = 8'h00;
        endcase
    end

    // ==========================================================================
    // Next state of the whole block.
    // ==========================================================================
    always_comb begin
        next_st = st;

        // Result crosses from the analog core through two flops.
        // The word is not gray coded: the core must hold it steady for a
        // few cycles before the run ends, which it does once settled.
        next_st.sync1   = coreResult;
        next_st.sync2   = st.sync1;
        next_st.tickOut = tick;

        // Write channel bookkeeping.
        // A beat taken alone is parked until its partner arrives; both
        // channels close while a response waits, so no write is lost.
        if (awFire && !wrEn) begin
            next_st.awHeld = 1'b1;
            next_st.awAddr = s_axi_awaddr;
        end
        if (wFire && !wrEn) begin
            next_st.wHeld  = 1'b1;
            next_st.wData  = s_axi_wdata[7:0];
            next_st.wStrb0 = s_axi_wstrb[0];
        end
        if (wrEn) begin
            next_st.awHeld = 1'b0;
            next_st.wHeld  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = (wrReg == sadc_pkg::SADC_REG_NONE) ? sadc_pkg::RESP_SLVERR : sadc_pkg::RESP_OKAY;
        end else if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        // Read channel: data is registered one cycle after the address.
        // Reads have no side effects, so reading status never clears it.
        if (s_axi_arvalid && s_axi_arready) begin
            next_st.rvalid = 1'b1;
            next_st.rdata  = {24'h000000, rdByte};
            next_st.rresp  = (rdReg == sadc_pkg::SADC_REG_NONE) ? sadc_pkg::RESP_SLVERR : sadc_pkg::RESP_OKAY;
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end

        // Conversion engine. The divider wraps once per converter tick and
        // the run ends on the last tick, so its length is exactly the
        // ratio times the tick count.
        if (st.fsm == sadc_pkg::SADC_CONV) begin
            next_st.divCnt = tick ? 5'h00 : st.divCnt + 5'h01;
            if (tick) begin
                next_st.tickCnt = st.tickCnt + 6'h01;
            end
            if (done) begin
                next_st.fsm     = sadc_pkg::SADC_IDLE;
                next_st.start   = 1'b0;
                next_st.eoc     = 1'b1;
                next_st.resHigh = st.sync2[11:4];
                if (st.convRes12) begin
                    next_st.resLow = st.sync2[3:0];
                end
            end
        end

        // Mode register: enable, start request, channel selection.
        // Channel and enable act at once, even in the middle of a run.
        if (wrLow && wrReg == sadc_pkg::SADC_REG_MODE) begin
            next_st.enable   = wrData[sadc_pkg::MODE_ENABLE_BIT];
            next_st.globalEn = wrData[sadc_pkg::MODE_GLOBAL_BIT];
            next_st.inputSel = wrData[3:0];
            if (!wrData[sadc_pkg::MODE_ENABLE_BIT]) begin
                // Disabling aborts; start and end flags keep their value.
                next_st.fsm = sadc_pkg::SADC_IDLE;
            end else if (wrData[sadc_pkg::MODE_START_BIT]) begin
                next_st.start = 1'b1;
                // A repeated start while busy does not restart the count.
                if (st.fsm == sadc_pkg::SADC_IDLE || done) begin
                    next_st.fsm       = sadc_pkg::SADC_CONV;
                    next_st.eoc       = 1'b0;
                    next_st.divCnt    = 5'h00;
                    next_st.tickCnt   = 6'h00;
                    // Settings are latched here, so late changes cannot upset a run.
                    next_st.divLast   = divLastOf(st.clkDiv);
                    next_st.tickLast  = st.res12 ? sadc_pkg::TICK_LAST_12 : sadc_pkg::TICK_LAST_8;
                    next_st.convRes12 = st.res12;
                end
            end else begin
                next_st.start = 1'b0;
                next_st.fsm   = sadc_pkg::SADC_IDLE;
            end
        end

        // Config part of the low-data register; the result nibble stays read-only.
        if (wrLow && wrReg == sadc_pkg::SADC_REG_LOW) begin
            next_st.clkDiv = {wrData[sadc_pkg::LOW_CLK1_BIT], wrData[sadc_pkg::LOW_CLK0_BIT]};
            next_st.res12  = wrData[sadc_pkg::LOW_RES_BIT];
        end

        if (wrLow && wrReg == sadc_pkg::SADC_REG_MASK) begin
            next_st.irqEnable = wrData[sadc_pkg::IRQ_DONE_BIT];
        end

        // Sticky flag: a completion in the clearing cycle wins.
        // Losing it would leave software waiting for an interrupt.
        next_st.irqFlag = (st.irqFlag && !irqClear) || done;
    end

    // State register.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st <= sadc_pkg::STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================================
    // Outputs toward the bus, the analog core and the CPU.
    // ==========================================================================
    // Each output is a flop, a plain gate of flops or a constant, so none of
    // them follows a bus input combinationally.
    assign s_axi_bvalid   = st.bvalid;
    assign s_axi_bresp    = st.bresp;
    assign s_axi_rvalid   = st.rvalid;
    assign s_axi_rdata    = st.rdata;
    assign s_axi_rresp    = st.rresp;
    assign converterPower = st.enable;
    assign channelSelect  = st.inputSel;
    // Reserved codes leave every input disconnected.
    assign channelConnect = st.enable && st.globalEn && (st.inputSel <= sadc_pkg::MAX_CHANNEL);
    assign resolution12   = st.convRes12;
    assign convClockTick  = st.tickOut;
    assign convBusy       = (st.fsm == sadc_pkg::SADC_CONV);
    assign irq            = st.irqFlag && st.irqEnable;
    assign irqVector      = sadc_pkg::IRQ_VECTOR;

    // ==========================================================================
    // Checks.
    // ==========================================================================
    logic [10:0] busyCycles;

    // Counts cycles spent converting, for the duration check.
    // It only feeds assertions and covers the slowest run.
    always_ff @(posedge mclk) begin
        if (!rst_n || !convBusy) begin
            busyCycles <= 11'h000;
        end else begin
            busyCycles <= busyCycles + 11'h001;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // A run begins only from both control bits.
    start_needs_enable_a: assert property ($rose(convBusy) |-> st.enable && st.start)
        else $error("conversion began without enable and start");

    // Completion loads both flags and the high byte.
    done_sets_flags_a: assert property (done |=> st.eoc && st.irqFlag && st.resHigh == $past(st.sync2[11:4]))
        else $error("completion did not set flags and result");

    // The request line follows a completion when enabled.
    irq_output_a: assert property (done && st.irqEnable && !wrEn |=> irq && irqVector == 8'h08)
        else $error("interrupt output does not follow flag and enable");

    // Only a software clear drops the flag.
    flag_sticky_a: assert property (st.irqFlag && !irqClear |=> st.irqFlag)
        else $error("irq flag dropped without a software clear");

    // A clear with no completion beside it does drop it.
    irq_clear_a: assert property (irqClear && !done |=> !st.irqFlag)
        else $error("irq flag not cleared by software write");

    // Start falls by itself at the end of a run.
    start_autoclear_a: assert property (done && !wrEn |=> !st.start && !convBusy)
        else $error("start bit not cleared at end of conversion");

    // The end flag is low for the whole run.
    eoc_low_busy_a: assert property (convBusy |-> !st.eoc)
        else $error("end flag high during conversion");

    // No run without power to the converter.
    busy_needs_power_a: assert property (convBusy |-> converterPower)
        else $error("converting while disabled");

    // Reserved codes and a cleared global bit isolate inputs.
    channel_gate_a: assert property (channelConnect |-> st.globalEn && st.inputSel <= 4'hb)
        else $error("input connected while disabled or reserved");

    // An 8-bit run leaves the low nibble alone.
    low_nibble_a: assert property (done && !st.convRes12 |=> st.resLow == $past(st.resLow))
        else $error("low nibble changed in 8-bit mode");

    // A 12-bit run fills the low nibble.
    nibble_load_a: assert property (done && st.convRes12 |=> st.resLow == $past(st.sync2[3:0]))
        else $error("low nibble not loaded in 12-bit mode");

    // Bus writes never reach the result buffers.
    result_readonly_a: assert property (wrEn && !done |=> st.resHigh == $past(st.resHigh)
                                        && st.resLow == $past(st.resLow))
        else $error("result buffer changed by a bus write");

    // Writing start as zero stops a run.
    stop_write_a: assert property (wrLow && wrReg == sadc_pkg::SADC_REG_MODE && wrData[7] && !wrData[6]
                                   |=> !convBusy && !st.start)
        else $error("start zero did not stop conversion");

    // The ratio comes from the clock field at start.
    divider_pick_a: assert property ($rose(convBusy) |-> st.divLast == (st.clkDiv == 2'h0 ? 5'h0f :
                                     st.clkDiv == 2'h1 ? 5'h07 : st.clkDiv == 2'h2 ? 5'h00 : 5'h01))
        else $error("converter clock ratio not taken from the clock field");

    // Resolution and tick count are latched at start.
    length_pick_a: assert property ($rose(convBusy) |-> st.convRes12 == st.res12
                                    && st.tickLast == (st.res12 ? 6'h3f : 6'h2f))
        else $error("resolution or length not latched at start");

    // The run lasts ratio times ticks cycles.
    duration_a: assert property (done |-> busyCycles ==
                                 11'((11'(st.divLast) + 11'h001) * (11'(st.tickLast) + 11'h001) - 11'h001))
        else $error("conversion length wrong");

    // A disabling write keeps both flags.
    disabled_keeps_a: assert property (wrLow && wrReg == sadc_pkg::SADC_REG_MODE && !wrData[7] && !done
                                       |=> st.start == $past(st.start) && st.eoc == $past(st.eoc))
        else $error("flags changed by write while disabled");

endmodule : sadc_control

// ---- common/sadc_pkg.sv ----
// Shared constants and types for the converter control block.
package sadc_pkg;

    // ==========================================================================
    // Register map: printed indices, byte address is four times the index.
    // ==========================================================================
    localparam int          ADDR_W         = 12;
    localparam logic [7:0]  IDX_MODE       = 8'hb1;
    localparam logic [7:0]  IDX_RES_HIGH   = 8'hb2;
    localparam logic [7:0]  IDX_RES_LOW    = 8'hb3;
    localparam logic [7:0]  IDX_IRQ_STATUS = 8'hb4;
    localparam logic [7:0]  IDX_IRQ_MASK   = 8'hb5;

    // ==========================================================================
    // Field positions.
    // ==========================================================================
    localparam int          MODE_ENABLE_BIT = 7;
    localparam int          MODE_START_BIT  = 6;
    localparam int          MODE_EOC_BIT    = 5;
    localparam int          MODE_GLOBAL_BIT = 4;
    localparam int          LOW_CLK1_BIT    = 6;
    localparam int          LOW_RES_BIT     = 5;
    localparam int          LOW_CLK0_BIT    = 4;
    localparam int          IRQ_DONE_BIT    = 0;
    localparam logic [3:0]  MAX_CHANNEL     = 4'hb;
    localparam logic [7:0]  IRQ_VECTOR      = 8'h08;

    // ==========================================================================
    // Converter clock division, stored as divide ratio minus one.
    // ==========================================================================
    localparam logic [1:0]  DIV_CODE_16  = 2'h0;
    localparam logic [1:0]  DIV_CODE_8   = 2'h1;
    localparam logic [1:0]  DIV_CODE_1   = 2'h2;
    localparam logic [1:0]  DIV_CODE_2   = 2'h3;
    localparam logic [4:0]  DIV_LAST_16  = 5'h0f;
    localparam logic [4:0]  DIV_LAST_8   = 5'h07;
    localparam logic [4:0]  DIV_LAST_1   = 5'h00;
    localparam logic [4:0]  DIV_LAST_2   = 5'h01;

    // ==========================================================================
    // Conversion length in converter clock ticks.
    // ==========================================================================
    localparam int          CLK_PER_PERIOD = 4;
    localparam int          PERIODS_12     = 16;
    localparam int          PERIODS_8      = 12;
    localparam logic [5:0]  TICK_LAST_12   = 6'(PERIODS_12 * CLK_PER_PERIOD - 1);
    localparam logic [5:0]  TICK_LAST_8    = 6'(PERIODS_8 * CLK_PER_PERIOD - 1);

    // ==========================================================================
    // Bus answers.
    // ==========================================================================
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SADC_IDLE = 2'b00,
        SADC_CONV = 2'b01
    } sadc_fsm_t;

    typedef enum logic [2:0] {
        SADC_REG_MODE   = 3'b000,
        SADC_REG_HIGH   = 3'b001,
        SADC_REG_LOW    = 3'b010,
        SADC_REG_STATUS = 3'b011,
        SADC_REG_MASK   = 3'b100,
        SADC_REG_NONE   = 3'b101
    } sadc_reg_t;

    typedef struct packed {
        logic              enable;
        logic              start;
        logic              eoc;
        logic              globalEn;
        logic [3:0]        inputSel;
        logic [1:0]        clkDiv;
        logic              res12;
        logic [7:0]        resHigh;
        logic [3:0]        resLow;
        logic              irqFlag;
        logic              irqEnable;
        sadc_fsm_t         fsm;
        logic [4:0]        divCnt;
        logic [5:0]        tickCnt;
        logic [4:0]        divLast;
        logic [5:0]        tickLast;
        logic              convRes12;
        logic              tickOut;
        logic [11:0]       sync1;
        logic [11:0]       sync2;
        logic              awHeld;
        logic [ADDR_W-1:0] awAddr;
        logic              wHeld;
        logic [7:0]        wData;
        logic              wStrb0;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } sadc_state_t;

    localparam sadc_state_t STATE_RESET = '0;

endpackage : sadc_pkg

// ---- bench/sadc_core_model.sv ----
// Behavioural model of the analog converter core and its input multiplexer.
`timescale 1ns/1ps
module sadc_core_model (
    input  wire logic        converterPower,
    input  wire logic [3:0]  channelSelect,
    input  wire logic        channelConnect,
    output logic      [11:0] coreResult
);
    // ==========================================================================
    // Sampled value
    // ==========================================================================
    // Each connected channel gives a code that names it, so a wrong select shows.
    // An open or unpowered input reads ground, the level the sample switch leaves.
    assign coreResult = (converterPower && channelConnect) ? {channelSelect, 8'h5a} : 12'h000;
endmodule : sadc_core_model

// ---- bench/tb_top.sv ----
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
module tb_top;
    logic        mclk, rst_n, awValid, awReady, wValid, wReady, bValid, bReady;
    logic        arValid, arReady, rValid, rReady, power, connect, res12, busy, irq, clkTick;
    logic [1:0]  bResp, rResp;
    logic [3:0]  chanSel;
    logic [7:0]  vec;
    logic [11:0] awAddr, arAddr, coreResult;
    logic [31:0] wData, rData;
    int          num_errors, n_checks, busyCnt, tickSeen;

    sadc_control uut (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'h1), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .coreResult(coreResult),
        .converterPower(power), .channelSelect(chanSel), .channelConnect(connect), .resolution12(res12),
        .convClockTick(clkTick), .convBusy(busy), .irq(irq), .irqVector(vec));
    sadc_core_model core (.converterPower(power), .channelSelect(chanSel), .channelConnect(connect),
        .coreResult(coreResult));

    // Clock and a busy-cycle counter; the counter sees the value from before each edge.
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) if (busy === 1'b1) busyCnt++;
    always @(posedge mclk) if (clkTick === 1'b1) tickSeen++;

    // ==========================================================================
    // Bus and check tasks
    // ==========================================================================
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // A wait that runs out of its bound ends the run at once.
    task automatic lim(input int t, input int m);
        if (t >= m) begin
            num_errors++;
            $display("[FAIL] wait expected done seen timeout");
            stop_test();
        end
    endtask : lim

    // Address and data go out together; each drops when taken; one idle edge follows.
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        int t;
        awAddr  <= a;
        wData   <= {24'h0, d};
        awValid <= 1'b1;
        wValid  <= 1'b1;
        bReady  <= 1'b1;
        for (t = 0; t < 100; t++) begin
            @(posedge mclk);
            if (awValid && awReady) awValid <= 1'b0;
            if (wValid && wReady) wValid <= 1'b0;
            if (bValid) break;
        end
        lim(t, 100);
        chk("bresp", 32'(bResp), 32'(er));
        bReady <= 1'b0;
        @(posedge mclk);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er, input string nm);
        int t;
        arAddr  <= a;
        arValid <= 1'b1;
        rReady  <= 1'b1;
        for (t = 0; t < 100; t++) begin
            @(posedge mclk);
            if (arValid && arReady) arValid <= 1'b0;
            if (rValid) break;
        end
        lim(t, 100);
        chk("rresp", 32'(rResp), 32'(er));
        chk(nm, rData, exp);
        rReady <= 1'b0;
        @(posedge mclk);
    endtask : rd

    // One conversion: configure, start, time it and read the mode register back.
    task automatic conv(input logic [7:0] cfg, input logic [7:0] mode, input int cyc, input int ticks);
        int t;
        wr(12'h2cc, cfg, 2'h0);
        busyCnt = 0;
        tickSeen = 0;
        wr(12'h2c4, mode, 2'h0);
        chk("busy", 32'(busy), 32'h1);
        rd(12'h2c4, 32'(mode), 2'h0, "mode running");
        for (t = 0; t < 2000 && busy !== 1'b0; t++) @(posedge mclk);
        lim(t, 2000);
        chk("cycles", 32'(busyCnt), 32'(cyc));
        rd(12'h2c4, 32'((mode & 8'hbf) | 8'h20), 2'h0, "mode done");
        chk("ticks", 32'(tickSeen), 32'(ticks));
    endtask : conv

    // ==========================================================================
    // Scenarios
    // ==========================================================================
    task automatic t_reset();
        rd(12'h2c4, 32'h0, 2'h0, "mode reset");
        rd(12'h2cc, 32'h0, 2'h0, "config reset");
        rd(12'h100, 32'h0, 2'h2, "unmapped");
        wr(12'h100, 8'hff, 2'h2);
        chk("vector", 32'(vec), 32'h8);
        $display("reset test done");
    endtask : t_reset

    task automatic t_conv();
        int ratio [4] = '{16, 8, 1, 2};
        logic [1:0] c;
        wr(12'h2d4, 8'h00, 2'h0);
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            conv({1'b0, c[1], 1'b0, c[0], 4'h0}, 8'hdb, ratio[i] * 48, 48);
        end
        rd(12'h2c8, 32'hb5, 2'h0, "high 8-bit");
        rd(12'h2cc, 32'h50, 2'h0, "low 8-bit");
        rd(12'h2d0, 32'h1, 2'h0, "irq flag");
        chk("irq masked", 32'(irq), 32'h0);
        wr(12'h2d4, 8'h01, 2'h0);
        chk("irq unmasked", 32'(irq), 32'h1);
        wr(12'h2d0, 8'h01, 2'h0);
        chk("irq cleared", 32'(irq), 32'h0);
        conv(8'h60, 8'hd3, 64, 64);
        chk("res12", 32'(res12), 32'h1);
        chk("irq raised", 32'(irq), 32'h1);
        wr(12'h2c8, 8'hff, 2'h0);
        rd(12'h2c8, 32'h35, 2'h0, "high 12-bit");
        rd(12'h2cc, 32'h6a, 2'h0, "low 12-bit");
        wr(12'h2d0, 8'h01, 2'h0);
        rd(12'h2d0, 32'h0, 2'h0, "irq clear");
        $display("conversion test done");
    endtask : t_conv

    task automatic t_abort();
        wr(12'h2cc, 8'h20, 2'h0);
        wr(12'h2c4, 8'hd3, 2'h0);
        wr(12'h2c4, 8'h93, 2'h0);
        chk("stop busy", 32'(busy), 32'h0);
        rd(12'h2c4, 32'h93, 2'h0, "mode stop");
        wr(12'h2c4, 8'h40, 2'h0);
        chk("off busy", 32'(busy), 32'h0);
        chk("power", 32'(power), 32'h0);
        rd(12'h2c4, 32'h00, 2'h0, "mode off");
        wr(12'h2c4, 8'h9c, 2'h0);
        chk("reserved", 32'(connect), 32'h0);
        wr(12'h2c4, 8'h8b, 2'h0);
        chk("global off", 32'(connect), 32'h0);
        $display("abort test done");
    endtask : t_abort

    // Main sequence: reset for two cycles, then the scenarios in turn.
    initial begin
        rst_n = 1'b0;
        {awValid, wValid, bReady, arValid, rReady} = '0;
        awAddr = '0;
        arAddr = '0;
        wData = '0;
        num_errors = 0;
        n_checks = 0;
        busyCnt = 0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_conv();
        t_abort();
        stop_test();
    end
endmodule : tb_top
